// File: insd_core.sv
// Integer-N synthesizer digital core: dividers, comparator, lock, fastlock, loader.
`timescale 1ns/1ps
`default_nettype none
module insd_core (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  input wire logic ref_source_in,
  input wire logic vco_feedback_in,
  output var insd_pkg::insd_cp_t cp_drive,
  output logic lock_detect,
  output logic monitor_pin,
  output logic monitor_oe
);
  import insd_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic sck_rise, sdat_lvl, le_rise, ref_rise, vco_rise;
  insd_sync u_sck (.clk(clk), .nrst(nrst), .pin(ser_clk), .level(), .rise(sck_rise));
  insd_sync u_sdat (.clk(clk), .nrst(nrst), .pin(ser_data), .level(sdat_lvl), .rise());
  insd_sync u_le (.clk(clk), .nrst(nrst), .pin(load_strobe), .level(), .rise(le_rise));
  insd_sync u_ref (.clk(clk), .nrst(nrst), .pin(ref_source_in), .level(), .rise(ref_rise));
  insd_sync u_vco (.clk(clk), .nrst(nrst), .pin(vco_feedback_in), .level(), .rise(vco_rise));

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Serial loader and latches
  logic [SHIFT_W-1:0] shift_ff;
  logic [R_W-1:0] r_val_ff;
  logic [1:0] abp_ff;
  logic ldp_ff;
  logic [A_W-1:0] a_val_ff;
  logic [B_W-1:0] b_val_ff;
  logic cpg_ff;
  logic [1:0] psc_sel_ff;
  logic [2:0] mux_sel_ff;
  logic fl_en_ff, fl_mode_ff;
  logic [3:0] tmr_code_ff;
  logic [2:0] cur1_ff, cur2_ff;
  logic init_rst_ff;
  insd_target_t tgt;
  logic ld_fb;
  assign tgt = insd_target_t'(shift_ff[TGT_LSB +: 2]);
  assign ld_fb = le_rise && (tgt == TGT_FB);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_ff <= '0;
    end else if (sck_rise) begin
      shift_ff <= {shift_ff[SHIFT_W-2:0], sdat_lvl};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_val_ff <= R_RST;
      abp_ff <= ABP_RST;
      ldp_ff <= 1'b0;
      a_val_ff <= A_RST;
      b_val_ff <= B_RST;
      cpg_ff <= 1'b0;
      psc_sel_ff <= PSC_RST;
      mux_sel_ff <= MUX_OFF;
      fl_en_ff <= 1'b0;
      fl_mode_ff <= 1'b0;
      tmr_code_ff <= TMR_RST;
      cur1_ff <= CUR1_RST;
      cur2_ff <= CUR2_RST;
      init_rst_ff <= 1'b0;
    end else begin
      init_rst_ff <= le_rise && (tgt == TGT_INIT);
      if (le_rise) begin
        unique case (tgt)
          TGT_REF: begin
            r_val_ff <= shift_ff[R_LSB +: R_W];
            abp_ff <= shift_ff[ABP_LSB +: 2];
            ldp_ff <= shift_ff[LDP_BIT];
          end
          TGT_FB: begin
            a_val_ff <= shift_ff[A_LSB +: A_W];
            b_val_ff <= shift_ff[B_LSB +: B_W];
            cpg_ff <= shift_ff[CPG_BIT];
          end
          TGT_FUNC, TGT_INIT: begin
            psc_sel_ff <= shift_ff[PSC_LSB +: 2];
            mux_sel_ff <= shift_ff[MUX_LSB +: 3];
            fl_en_ff <= shift_ff[FLE_BIT];
            fl_mode_ff <= shift_ff[FLM_BIT];
            tmr_code_ff <= shift_ff[TMR_LSB +: 4];
            cur1_ff <= shift_ff[CUR1_LSB +: 3];
            cur2_ff <= shift_ff[CUR2_LSB +: 3];
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Prescaler, swallow and main counters
  logic [6:0] psc_cnt_ff, psc_p, psc_mod;
  logic [A_W-1:0] a_cnt_ff;
  logic [B_W-1:0] b_cnt_ff;
  logic fb_pulse_ff, psc_tick;
  assign psc_p = 7'h08 << psc_sel_ff;
  // larger modulus while swallow count remains
  assign psc_mod = (a_cnt_ff != '0) ? psc_p + 7'h01 : psc_p;
  assign psc_tick = vco_rise && (psc_cnt_ff == psc_mod - 7'h01);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      psc_cnt_ff <= 7'h00;
    end else if (init_rst_ff || psc_tick) begin
      psc_cnt_ff <= 7'h00;
    end else if (vco_rise) begin
      psc_cnt_ff <= psc_cnt_ff + 7'h01;
    end
  end

  // N = A + P*B; relies on B >= A from the host
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_cnt_ff <= A_RST;
      b_cnt_ff <= B_RST;
      fb_pulse_ff <= 1'b0;
    end else begin
      fb_pulse_ff <= 1'b0;
      if (init_rst_ff) begin
        a_cnt_ff <= a_val_ff;
        b_cnt_ff <= b_val_ff;
      end else if (psc_tick) begin
        if (b_cnt_ff <= 13'h0001) begin
          a_cnt_ff <= a_val_ff;
          b_cnt_ff <= b_val_ff;
          fb_pulse_ff <= 1'b1;
        end else begin
          b_cnt_ff <= b_cnt_ff - 13'h0001;
          if (a_cnt_ff != '0) begin
            a_cnt_ff <= a_cnt_ff - 6'h01;
          end
        end
      end
    end
  end

  // ==========================================================
  // Reference divider
  logic [R_W-1:0] r_cnt_ff, r_div;
  logic ref_pulse_ff;
  assign r_div = (r_val_ff == '0) ? 14'h0001 : r_val_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_cnt_ff <= '0;
      ref_pulse_ff <= 1'b0;
    end else begin
      ref_pulse_ff <= 1'b0;
      if (init_rst_ff) begin
        r_cnt_ff <= '0;
      end else if (ref_rise) begin
        if (r_cnt_ff >= r_div - 14'h0001) begin
          r_cnt_ff <= '0;
          ref_pulse_ff <= 1'b1;
        end else begin
          r_cnt_ff <= r_cnt_ff + 14'h0001;
        end
      end
    end
  end

  // ==========================================================
  // Phase comparator
  insd_pfd_state_t st_ff;
  logic [2:0] abl_cnt_ff, abl_len;
  logic [5:0] err_cnt_ff, err_hold_ff;
  logic eval_ff;
  always_comb begin
    unique case (abp_ff)
      2'h1: abl_len = 3'(ABP_SHORT_CYC);
      2'h2: abl_len = 3'(ABP_LONG_CYC);
      default: abl_len = 3'(ABP_MID_CYC);
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= PC_IDLE;
      abl_cnt_ff <= 3'h0;
      err_cnt_ff <= 6'h00;
      err_hold_ff <= 6'h00;
      eval_ff <= 1'b0;
    end else begin
      eval_ff <= 1'b0;
      unique case (st_ff)
        PC_IDLE: begin
          err_cnt_ff <= 6'h00;
          abl_cnt_ff <= 3'h1;
          if (ref_pulse_ff && fb_pulse_ff) begin
            st_ff <= PC_ABL;
            err_hold_ff <= 6'h00;
            eval_ff <= 1'b1;
          end else if (ref_pulse_ff) begin
            st_ff <= PC_UP;
          end else if (fb_pulse_ff) begin
            st_ff <= PC_DN;
          end
        end
        PC_UP, PC_DN: begin
          if (err_cnt_ff != 6'h3f) begin
            err_cnt_ff <= err_cnt_ff + 6'h01;
          end
          if ((st_ff == PC_UP) ? fb_pulse_ff : ref_pulse_ff) begin
            st_ff <= PC_ABL;
            // A saturated count must not wrap, or a long error would read as none.
            err_hold_ff <= (err_cnt_ff == 6'h3f) ? 6'h3f : err_cnt_ff + 6'h01;
            eval_ff <= 1'b1;
          end
        end
        PC_ABL: begin
          abl_cnt_ff <= abl_cnt_ff + 3'h1;
          if (abl_cnt_ff >= abl_len) begin
            st_ff <= PC_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Digital lock detect
  logic [2:0] streak_ff, need;
  logic lock_ff;
  assign need = ldp_ff ? 3'(LOCK_NEED_HI) : 3'(LOCK_NEED_LO);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      streak_ff <= 3'h0;
      lock_ff <= 1'b0;
    end else if (eval_ff) begin
      if (err_hold_ff > 6'(LOCK_BAD_CYC)) begin
        streak_ff <= 3'h0;
        lock_ff <= 1'b0;
      end else if (err_hold_ff < 6'(LOCK_OK_CYC)) begin
        if (streak_ff < need) begin
          streak_ff <= streak_ff + 3'h1;
        end
        if (streak_ff + 3'h1 >= need) begin
          lock_ff <= 1'b1;
        end
      end else begin
        streak_ff <= 3'h0;
      end
    end
  end

  // ==========================================================
  // Fastlock and current selection
  logic fl_active_ff;
  logic [5:0] tmr_ff;
  insd_cp_t cp_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fl_active_ff <= 1'b0;
      tmr_ff <= 6'h00;
    end else if (ld_fb) begin
      fl_active_ff <= fl_en_ff && shift_ff[CPG_BIT];
      tmr_ff <= 6'(TMR_BASE) + 6'(TMR_STEP) * {2'h0, tmr_code_ff};
    end else if (!fl_en_ff) begin
      fl_active_ff <= 1'b0;
    end else if (fl_active_ff && fl_mode_ff && ref_pulse_ff) begin
      if (tmr_ff <= 6'h01) begin
        fl_active_ff <= 1'b0;
      end
      tmr_ff <= tmr_ff - 6'h01;
    end
  end

  // setting one unless fastlock is active
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cp_ff <= '0;
    end else begin
      cp_ff.up <= (st_ff == PC_UP) || (st_ff == PC_ABL);
      cp_ff.dn <= (st_ff == PC_DN) || (st_ff == PC_ABL);
      cp_ff.fast <= fl_active_ff;
      cp_ff.current <= fl_active_ff ? cur2_ff : cur1_ff;
    end
  end

  // ==========================================================
  // Monitor multiplexer
  logic mon_ff, mon_oe_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mon_ff <= 1'b0;
      mon_oe_ff <= 1'b0;
    end else begin
      mon_ff <= 1'b0;
      mon_oe_ff <= 1'b1;
      unique case (mux_sel_ff)
        MUX_DLOCK: mon_ff <= lock_ff;
        MUX_NDIV: mon_ff <= fb_pulse_ff;
        MUX_RDIV: mon_ff <= ref_pulse_ff;
        MUX_ALOCK: mon_oe_ff <= (st_ff != PC_IDLE);
        MUX_HIGH: mon_ff <= 1'b1;
        MUX_LOW: mon_ff <= 1'b0;
        default: mon_oe_ff <= 1'b0;
      endcase
    end
  end

  assign cp_drive = cp_ff;
  assign lock_detect = lock_ff;
  assign monitor_pin = mon_ff;
  assign monitor_oe = mon_oe_ff;

  // ==========================================================
  // Checks
  sequence ref_alone_s;
    st_ff == PC_IDLE && ref_pulse_ff && !fb_pulse_ff;
  endsequence
  sequence up_drive_s;
    st_ff == PC_UP ##1 cp_ff.up && !cp_ff.dn;
  endsequence
  psc_range_a: assert property (psc_mod >= 7'h08 && psc_mod <= 7'h41)
    else $error("prescaler modulus out of range");
  swallow_dec_a: assert property (psc_tick && !init_rst_ff && b_cnt_ff > 13'h0001
    && a_cnt_ff != '0 |=> a_cnt_ff == $past(a_cnt_ff) - 6'h01)
    else $error("swallow count did not step");
  main_reload_a: assert property (psc_tick && !init_rst_ff && b_cnt_ff <= 13'h0001
    |=> fb_pulse_ff && b_cnt_ff == $past(b_val_ff))
    else $error("main counter did not reload");
  ref_div_a: assert property (ref_pulse_ff |-> r_cnt_ff == '0)
    else $error("reference pulse off count");
  pfd_up_a: assert property (ref_alone_s |=> up_drive_s)
    else $error("up drive missing");
  abl_width_a: assert property (st_ff == PC_ABL && abl_cnt_ff >= abl_len
    |=> st_ff == PC_IDLE && cp_ff.up && cp_ff.dn)
    else $error("anti-backlash cut short");
  lock_need_a: assert property ($rose(lock_ff) |-> streak_ff == need)
    else $error("lock rose early");
  unlock_a: assert property (eval_ff && err_hold_ff > 6'(LOCK_BAD_CYC) |=> !lock_ff)
    else $error("lock kept after large error");
  cur_norm_a: assert property (nrst && !fl_active_ff |=> cp_ff.current == $past(cur1_ff))
    else $error("wrong steady current");
  fl1_hold_a: assert property (fl_active_ff && !fl_mode_ff && !le_rise
    && fl_en_ff |=> fl_active_ff)
    else $error("fastlock one left early");
  fl2_start_a: assert property (ld_fb && fl_en_ff && shift_ff[CPG_BIT]
    |=> fl_active_ff && tmr_ff == 6'h03 + 6'h04 * {2'h0, $past(tmr_code_ff)})
    else $error("fastlock timer load wrong");
  fl2_expire_a: assert property (fl_active_ff && fl_mode_ff && ref_pulse_ff
    && tmr_ff == 6'h01 && !ld_fb |=> !fl_active_ff ##1 !cp_ff.fast)
    else $error("fastlock two did not expire");
  shift_in_a: assert property (sck_rise |=> shift_ff[0] == $past(sdat_lvl))
    else $error("serial bit not captured");
  load_sel_a: assert property (ld_fb
    |=> b_val_ff == $past(shift_ff[B_LSB +: B_W]) && a_val_ff == $past(shift_ff[A_LSB +: A_W]))
    else $error("feedback latch not loaded");
  mux_lock_a: assert property (mux_sel_ff == MUX_DLOCK |=> mon_ff == $past(lock_ff))
    else $error("monitor not showing lock");
endmodule : insd_core
`default_nettype wire

// File: insd_pkg.sv
// Constants and types shared by the integer-N synthesizer divider core.
package insd_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PS = 20000;
  localparam int ABP_MID_PS = 3000;
  localparam int ABP_SHORT_PS = 1500;
  localparam int ABP_LONG_PS = 6000;
  localparam int ABP_MID_CYC = (ABP_MID_PS + CLK_PS - 1) / CLK_PS;
  localparam int ABP_SHORT_CYC = (ABP_SHORT_PS + CLK_PS - 1) / CLK_PS;
  localparam int ABP_LONG_CYC = (ABP_LONG_PS + CLK_PS - 1) / CLK_PS;
  localparam int LOCK_OK_NS = 15;
  localparam int LOCK_BAD_NS = 25;
  localparam int LOCK_OK_RAW = LOCK_OK_NS * 1000 / CLK_PS;
  localparam int LOCK_BAD_RAW = LOCK_BAD_NS * 1000 / CLK_PS;
  localparam int LOCK_OK_CYC = (LOCK_OK_RAW < 1) ? 1 : LOCK_OK_RAW;
  localparam int LOCK_BAD_CYC = (LOCK_BAD_RAW < 1) ? 1 : LOCK_BAD_RAW;
  localparam int LOCK_NEED_LO = 3;
  localparam int LOCK_NEED_HI = 5;
  localparam int TMR_BASE = 3;
  localparam int TMR_STEP = 4;

  // ==========================================================
  // Widths and field positions of the 24-bit word
  localparam int SHIFT_W = 24;
  localparam int A_W = 6;
  localparam int B_W = 13;
  localparam int R_W = 14;
  localparam int TGT_LSB = 0;
  localparam int R_LSB = 2;
  localparam int ABP_LSB = 16;
  localparam int LDP_BIT = 20;
  localparam int A_LSB = 2;
  localparam int B_LSB = 8;
  localparam int CPG_BIT = 21;
  localparam int PSC_LSB = 2;
  localparam int MUX_LSB = 4;
  localparam int FLE_BIT = 7;
  localparam int FLM_BIT = 8;
  localparam int TMR_LSB = 9;
  localparam int CUR1_LSB = 13;
  localparam int CUR2_LSB = 16;

  // ==========================================================
  // Reset values
  localparam logic [13:0] R_RST = 14'h0001;
  localparam logic [12:0] B_RST = 13'h0003;
  localparam logic [5:0] A_RST = 6'h00;
  localparam logic [1:0] PSC_RST = 2'h0;
  localparam logic [1:0] ABP_RST = 2'h0;
  localparam logic [3:0] TMR_RST = 4'h0;
  localparam logic [2:0] CUR1_RST = 3'h3;
  localparam logic [2:0] CUR2_RST = 3'h7;

  // ==========================================================
  // Monitor selections and enumerations
  localparam logic [2:0] MUX_OFF = 3'h0;
  localparam logic [2:0] MUX_DLOCK = 3'h1;
  localparam logic [2:0] MUX_NDIV = 3'h2;
  localparam logic [2:0] MUX_RDIV = 3'h3;
  localparam logic [2:0] MUX_ALOCK = 3'h4;
  localparam logic [2:0] MUX_HIGH = 3'h5;
  localparam logic [2:0] MUX_LOW = 3'h6;

  typedef enum logic [1:0] {
    TGT_REF = 2'b00,
    TGT_FB = 2'b01,
    TGT_FUNC = 2'b10,
    TGT_INIT = 2'b11
  } insd_target_t;

  typedef enum logic [1:0] {
    PC_IDLE = 2'b00,
    PC_UP = 2'b01,
    PC_DN = 2'b10,
    PC_ABL = 2'b11
  } insd_pfd_state_t;

  typedef struct packed {
    logic up;
    logic dn;
    logic fast;
    logic [2:0] current;
  } insd_cp_t;

endpackage : insd_pkg

// File: insd_sync.sv
// Three-stage pin synchroniser with agreement filter and rise pulse.
`timescale 1ns/1ps
`default_nettype none
module insd_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic [2:0] stg_ff;
  logic lvl_ff;
  logic rise_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stg_ff <= 3'h0;
    end else begin
      stg_ff <= {stg_ff[1:0], pin};
    end
  end

  // A change only counts once the second and third stages agree.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lvl_ff <= 1'b0;
      rise_ff <= 1'b0;
    end else begin
      if (stg_ff[1] == stg_ff[2]) begin
        lvl_ff <= stg_ff[2];
      end
      rise_ff <= (stg_ff[1] == stg_ff[2]) & stg_ff[2] & ~lvl_ff;
    end
  end

  assign level = lvl_ff;
  assign rise = rise_ff;
endmodule : insd_sync
`default_nettype wire

// File: insd_host.sv
// Host-side model of the three-wire programming port.
`timescale 1ns/1ps
`default_nettype none
module insd_host (
  input wire logic clk,
  output logic ser_clk,
  output logic ser_data,
  output logic load_strobe
);
  import insd_pkg::*;

  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
  end

  // ==========================================================
  // Word transfer
  task automatic send_word(input logic [SHIFT_W-1:0] w);
    for (int i = SHIFT_W - 1; i >= 0; i--) begin
      @(posedge clk) ser_data <= w[i];
      repeat (2) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge clk);
      ser_clk <= 1'b0;
      repeat (2) @(posedge clk);
    end
    // The data line has no pull, so it shows garbage once the word is over.
    ser_data <= ~w[0];
    repeat (2) @(posedge clk);
    load_strobe <= 1'b1;
    repeat (4) @(posedge clk);
    load_strobe <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : send_word
endmodule : insd_host
`default_nettype wire

// File: insd_tb.sv
// Self-checking testbench for the synthesizer divider core.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin #1; num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp=%0h got=%0h", nm, e, g); end end
module tb;
  import insd_pkg::*;
  logic clk, nrst, ref_in, vco_in, mon_pin, mon_oe, lock, mon_q, sclk, sdat, lstb;
  insd_cp_t cp;
  int n_fail = 0;
  int num_checks = 0;
  int mon_rises = 0;

  insd_host host (.clk(clk), .ser_clk(sclk), .ser_data(sdat), .load_strobe(lstb));
  insd_core dut (.clk(clk), .nrst(nrst), .ser_clk(sclk), .ser_data(sdat),
    .load_strobe(lstb), .ref_source_in(ref_in), .vco_feedback_in(vco_in),
    .cp_drive(cp), .lock_detect(lock), .monitor_pin(mon_pin), .monitor_oe(mon_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial mon_q = 1'b0;
  always @(posedge clk) begin
    mon_rises += int'(mon_pin && !mon_q);
    mon_q = mon_pin;
  end

  // ==========================================================
  // Word builders
  // Target in low bits
  function automatic logic [23:0] fw(input logic [1:0] p, input logic [2:0] m,
    input logic [1:0] fl, input logic [3:0] t, input logic [1:0] g);
    fw = (24'(p) << PSC_LSB) | (24'(m) << MUX_LSB) | (24'(fl) << FLE_BIT)
      | (24'(t) << TMR_LSB) | (24'h2 << CUR1_LSB) | (24'h5 << CUR2_LSB) | 24'(g);
  endfunction : fw

  // Main count kept at or above swallow count
  function automatic logic [23:0] nw(input logic [5:0] a, input logic [12:0] b,
    input logic gn);
    nw = (24'(a) << A_LSB) | (24'(b) << B_LSB) | (24'(gn) << CPG_BIT) | 24'h1;
  endfunction : nw

  function automatic logic [23:0] rw(input logic [13:0] r, input logic ldp);
    rw = (24'(r) << R_LSB) | (24'(ldp) << LDP_BIT);
  endfunction : rw

  // ==========================================================
  // Pin stimulus
  // Pin rates stay far below the counter limit
  task automatic drive(input int np, input bit von, input int re, input int sk);
    for (int i = 0; i < np * 8; i++) begin
      @(posedge clk);
      vco_in <= von && (i % 8 < 4);
      ref_in <= re > 0 && (i / 8) % re == re - 1 && i % 8 >= sk && i % 8 < sk + 4;
    end
    @(posedge clk);
    vco_in <= 1'b0;
    ref_in <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : drive

  // ==========================================================
  // Scenarios
  task automatic t_lock();
    host.send_word(fw(2'h0, MUX_DLOCK, 2'h0, 4'h0, TGT_FUNC));
    drive(48, 1, 24, 0);
    `CHK("lock_early", 1'b0, lock)
    drive(48, 1, 24, 0);
    `CHK("lock_set", 1'b1, lock)
    `CHK("mon_lock", 1'b1, mon_pin)
    drive(24, 1, 24, 3);
    `CHK("lock_drop", 1'b0, lock)
    host.send_word(rw(14'h1, 1'b1));
    drive(96, 1, 24, 0);
    `CHK("lock5_early", 1'b0, lock)
    drive(48, 1, 24, 0);
    `CHK("lock5_set", 1'b1, lock)
  endtask : t_lock

  task automatic t_target();
    for (int t = 0; t < 4; t++) begin
      host.send_word(fw(2'h0, MUX_OFF, 2'h0, 4'h0, TGT_FUNC));
      host.send_word(fw(2'h0, MUX_HIGH, 2'h0, 4'h0, 2'(t)));
      `CHK("tgt_oe", t[1], mon_oe)
    end
    `CHK("mon_high", 1'b1, mon_pin)
    host.send_word(fw(2'h0, MUX_LOW, 2'h0, 4'h0, TGT_FUNC));
    `CHK("mon_low", 2'b10, {mon_oe, mon_pin})
  endtask : t_target

  task automatic t_rdiv();
    int c;
    host.send_word(rw(14'h3, 1'b0));
    host.send_word(fw(2'h0, MUX_RDIV, 2'h0, 4'h0, TGT_INIT));
    c = mon_rises;
    drive(31, 0, 1, 0);
    `CHK("rdiv_pulses", 10, mon_rises - c)
  endtask : t_rdiv

  task automatic t_ndiv();
    int c;
    int n;
    host.send_word(nw(6'h1, 13'h3, 1'b0));
    for (int p = 0; p < 4; p++) begin
      n = 1 + (8 << p) * 3;
      host.send_word(fw(2'(p), MUX_NDIV, 2'h0, 4'h0, TGT_INIT));
      c = mon_rises;
      drive(2 * n + n / 2, 1, 0, 0);
      `CHK("ndiv_pulses", 2, mon_rises - c)
    end
  endtask : t_ndiv

  task automatic t_fast();
    host.send_word(rw(14'h1, 1'b0));
    for (int k = 0; k < 2; k++) begin
      host.send_word(fw(2'h0, MUX_OFF, 2'h3, 4'(k), TGT_FUNC));
      host.send_word(nw(6'h0, 13'h3, 1'b1));
      `CHK("fl2_on", 4'hd, {cp.fast, cp.current})
      drive(4 * k + 1, 0, 1, 0);
      `CHK("fl2_hold", 1'b1, cp.fast)
      drive(3, 0, 1, 0);
      `CHK("fl2_off", 4'h2, {cp.fast, cp.current})
      `CHK("cmp_up", 2'b10, {cp.up, cp.dn})
    end
    // The comparator is still pumping up, so the open-drain monitor pulls low.
    host.send_word(fw(2'h0, MUX_ALOCK, 2'h0, 4'h0, TGT_FUNC));
    `CHK("mon_alock", 2'b10, {mon_oe, mon_pin})
    host.send_word(fw(2'h0, MUX_OFF, 2'h1, 4'h0, TGT_FUNC));
    host.send_word(nw(6'h0, 13'h3, 1'b1));
    drive(70, 0, 1, 0);
    `CHK("fl1_hold", 4'hd, {cp.fast, cp.current})
    host.send_word(nw(6'h0, 13'h3, 1'b0));
    `CHK("fl1_off", 4'h2, {cp.fast, cp.current})
  endtask : t_fast

  task automatic summarize();
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // ==========================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    ref_in = 1'b0;
    vco_in = 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("cp_reset", {3'h0, CUR1_RST}, cp)
    `CHK("outs_reset", 2'b00, {lock, mon_oe})
    t_lock();
    t_target();
    t_rdiv();
    t_ndiv();
    t_fast();
    summarize();
  end

  // A hang is cut short here and reported as a mismatch.
  initial begin
    #1200000;
    n_fail++;
    summarize();
  end
endmodule : tb
`default_nettype wire
